// ### design/eidack_pkg.sv
// Package of constants and carriers for the external interrupt detect block
package eidack_pkg;
  localparam int unsigned NUM_REQ       = 4;
  localparam logic        FLAGS_RESET   = 1'b0;
  localparam logic        STROBE_IDLE   = 1'b1;
  localparam logic [3:0]  PINS_IDLE     = 4'hF;

  // Core-side handshake for taking interrupts and acknowledging
  typedef struct packed {
    logic       fetch_boundary;
    logic [3:0] accept;
    logic [3:0] sw_clear;
    logic       ack_decode;
    logic       ack_read;
  } eidack_core_t;
endpackage : eidack_pkg

// ### design/eidack_top.sv
// External interrupt detection, pending flags and acknowledge strobe
`timescale 1ns/1ps
`default_nettype none
module eidack_top (
  // Clock and reset
  input  wire logic                    core_clk,
  input  wire logic                    reset,
  // Phase timing from the core clock generator
  input  wire logic                    phase_one_clock,
  // Mode select
  input  wire logic                    falling_edge_select,
  // External request pins
  input  wire logic [3:0]              ext_request_pins_n,
  // Core side
  input  wire eidack_pkg::eidack_core_t core_in,
  // Results
  output logic      [3:0]              pending_ff,
  output logic      [3:0]              take_ff,
  output logic                         ack_strobe_n
);
  import eidack_pkg::*;

  logic [3:0] req_s1_ff;
  logic [3:0] req_s2_ff;
  logic [3:0] req_s3_ff;
  logic [3:0] req_ff;
  logic [3:0] req_prev_ff;
  logic       ph1_s1_ff;
  logic       ph1_s2_ff;
  logic       ph1_s3_ff;
  logic       ph1_ff;
  logic       ph1_prev_ff;
  logic       ph1_fall;
  logic [3:0] clr;
  logic [3:0] detect;
  logic [3:0] nxt_pending;
  logic [3:0] edge_seen_ff;

  // Three-stage synchronisers; a change counts when stages two and three agree
  always_ff @(posedge core_clk) begin
    if (reset) begin
      req_s1_ff <= PINS_IDLE;
      req_s2_ff <= PINS_IDLE;
      req_s3_ff <= PINS_IDLE;
      req_ff    <= PINS_IDLE;
      ph1_s1_ff <= 1'b0;
      ph1_s2_ff <= 1'b0;
      ph1_s3_ff <= 1'b0;
      ph1_ff    <= 1'b0;
    end else begin
      req_s1_ff <= ext_request_pins_n;
      req_s2_ff <= req_s1_ff;
      req_s3_ff <= req_s2_ff;
      for (int i = 0; i < NUM_REQ; i++) begin
        if (req_s2_ff[i] == req_s3_ff[i]) begin
          req_ff[i] <= req_s3_ff[i];
        end
      end
      ph1_s1_ff <= phase_one_clock;
      ph1_s2_ff <= ph1_s1_ff;
      ph1_s3_ff <= ph1_s2_ff;
      if (ph1_s2_ff == ph1_s3_ff) begin
        ph1_ff <= ph1_s3_ff;
      end
    end
  end

  // History for edge detection on the filtered signals
  always_ff @(posedge core_clk) begin
    if (reset) begin
      req_prev_ff <= PINS_IDLE;
      ph1_prev_ff <= 1'b0;
    end else begin
      req_prev_ff <= req_ff;
      ph1_prev_ff <= ph1_ff;
    end
  end

  // Sampling instant at phase-one fall
  assign ph1_fall = ph1_prev_ff & ~ph1_ff;

  // Falling transitions latched on the core clock until the next sample
  always_ff @(posedge core_clk) begin
    if (reset) begin
      edge_seen_ff <= 4'h0;
    end else if (ph1_fall) begin
      edge_seen_ff <= req_prev_ff & ~req_ff;
    end else begin
      edge_seen_ff <= edge_seen_ff | (req_prev_ff & ~req_ff);
    end
  end

  // Detection per mode; a late pin is simply caught one sample later
  always_comb begin
    if (falling_edge_select) begin
      detect = {4{ph1_fall}} & (edge_seen_ff | (req_prev_ff & ~req_ff));
    end else begin
      detect = {4{ph1_fall}} & ~req_ff;
    end
  end

  // Clears from core acceptance or software
  assign clr = core_in.accept | core_in.sw_clear;

  // Clear wins over a coincident sample; set again from the next sample on
  always_comb begin
    nxt_pending = (pending_ff | detect) & ~clr;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      pending_ff <= {NUM_REQ{FLAGS_RESET}};
    end else begin
      pending_ff <= nxt_pending;
    end
  end

  // Pending flags reach the core only at a fetch boundary
  always_ff @(posedge core_clk) begin
    if (reset) begin
      take_ff <= 4'h0;
    end else if (core_in.fetch_boundary) begin
      take_ff <= pending_ff & ~clr;
    end else begin
      take_ff <= 4'h0;
    end
  end

  // Acknowledge strobe, independent of any interrupt service
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ack_strobe_n <= STROBE_IDLE;
    end else if (core_in.ack_decode) begin
      ack_strobe_n <= 1'b0;
    end else if (core_in.ack_read) begin
      ack_strobe_n <= 1'b1;
    end
  end
endmodule : eidack_top
`default_nettype wire

// ### dv/eidack_src.sv
// Phase-one clock and request pin model
`timescale 1ns/1ps
`default_nettype none
module eidack_src (input wire logic core_clk, input wire logic [3:0] fire,
  output logic phase_one_clock, output logic [3:0] ext_request_pins_n);
  logic [3:0] ph_ff = 4'h0;
  always_ff @(posedge core_clk) ph_ff <= ph_ff + 4'h1;
  assign phase_one_clock    = ph_ff[3];
  assign ext_request_pins_n = ~fire;
endmodule // eidack_src
`default_nettype wire

// ### dv/eidack_chk.sv
// Port assertions for the interrupt detect block
`timescale 1ns/1ps
`default_nettype none
module eidack_chk (input wire logic core_clk, reset, phase_one_clock,
  input wire logic falling_edge_select, ack_strobe_n,
  input wire logic [3:0] ext_request_pins_n, pending_ff, take_ff,
  input wire eidack_pkg::eidack_core_t core_in);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  AST_ACK_LOW: assert property (
    core_in.ack_decode |=> !ack_strobe_n) else $error("ack not low");
  AST_ACK_HIGH: assert property (
    core_in.ack_read && !core_in.ack_decode |=> ack_strobe_n) else $error("ack");
  AST_ACK_FELL: assert property (
    $fell(ack_strobe_n) |-> $past(core_in.ack_decode)) else $error("ack fell");
  AST_CLR_WINS: assert property (
    (pending_ff & $past(core_in.accept | core_in.sw_clear)) == 4'h0) else $error("clr");
  AST_TAKE_FETCH: assert property (
    |take_ff |-> $past(core_in.fetch_boundary)) else $error("take off boundary");
  AST_TAKE_PEND: assert property (
    (take_ff & ~$past(pending_ff)) == 4'h0) else $error("take not pending");
  AST_SET_PHASE: assert property (
    |(pending_ff & ~$past(pending_ff)) |-> !$past(phase_one_clock, 3)) else $error("ph");
  AST_LEVEL_SET: assert property (
    !falling_edge_select |-> (pending_ff & ~$past(pending_ff) &
    $past(ext_request_pins_n, 3) & $past(ext_request_pins_n, 7)) == 4'h0) else $error("lvl");
  cover property (core_in.ack_decode);
  cover property (|take_ff);
  cover property (falling_edge_select && |pending_ff);
endmodule // eidack_chk
bind eidack_top eidack_chk eidack_chk_inst (.*);
`default_nettype wire

// ### dv/tb_top.sv
// Self-checking bench for the interrupt detect block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic core_clk = 1'b0, reset = 1'b1, falling_edge_select = 1'b0;
  logic phase_one_clock, ack_strobe_n;
  logic [3:0] ext_request_pins_n, pending_ff, take_ff, m, fire = 4'h0;
  eidack_pkg::eidack_core_t core_in = '0;
  int n_mismatch = 0, n_compared = 0;
  initial forever #25 core_clk = ~core_clk;
  eidack_src eidack_src_inst (.*);
  eidack_top eidack_top_inst (.*);
  task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
    n_compared++;
    if (seen !== exp) n_mismatch++;
    if (seen !== exp) $display("ERROR %0t saw %h want %h", $time, seen, exp);
  endtask
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    void'($urandom(32'hF20F));
    repeat (10) @(posedge core_clk);
    reset <= 1'b0;
    core_in.ack_decode <= 1'b1;
    @(posedge core_clk) core_in.ack_decode <= 1'b0;
    core_in.ack_read <= 1'b1;
    #1 chk({3'h0, ack_strobe_n}, 4'h0);
    @(posedge core_clk) core_in.ack_read <= 1'b0;
    for (int k = 0; k < 6; k++) begin
      m = (k == 5) ? 4'hF : 4'($urandom_range(15, 1));
      falling_edge_select <= k[0];
      core_in.fetch_boundary <= k[1];
      fire <= m;
      repeat (24) @(posedge core_clk);
      fire <= 4'h0;
      repeat (8) @(posedge core_clk);
      {core_in.accept, core_in.sw_clear} <= {m & 4'h5, m & 4'hA};
      #1 chk(pending_ff, m);
      chk(take_ff, k[1] ? m : 4'h0);
      @(posedge core_clk) {core_in.accept, core_in.sw_clear} <= 8'h00;
      #1 chk(pending_ff, 4'h0);
    end
    falling_edge_select <= 1'b0;
    fire <= 4'h1;
    repeat (24) @(posedge core_clk);
    core_in.sw_clear <= 4'h1;
    #1 chk(pending_ff, 4'h1);
    @(posedge core_clk) core_in.sw_clear <= 4'h0;
    #1 chk(pending_ff, 4'h0);
    repeat (20) @(posedge core_clk);
    fire <= 4'h0;
    #1 chk(pending_ff, 4'h1);
    repeat (8) @(posedge core_clk);
    core_in.sw_clear <= 4'h1;
    @(posedge core_clk) core_in.sw_clear <= 4'h0;
    #1 chk(pending_ff, 4'h0);
    report_and_stop;
  end
endmodule // tb_top
`default_nettype wire
